// ---- verilog/ftc_consts.svh ----
// Register offsets, field positions and reset values for the fan tachometer block
`ifndef FTC_CONSTS_SVH
`define FTC_CONSTS_SVH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define FTC_IDX_CTRL 8'h58
`define FTC_IDX_CNT1 8'h59
`define FTC_IDX_CNT2 8'h5A
`define FTC_IDX_CFG1 8'h5B
`define FTC_IDX_CFG2 8'h5C

// ----------------------------------------
// Control register fields and the config register range bit
// ----------------------------------------
`define FTC_SPD1_BIT 0
`define FTC_SPD2_BIT 1
`define FTC_MUL1_BIT 2
`define FTC_MUL2_BIT 3
`define FTC_DIV1_LSB 4
`define FTC_DIV2_LSB 6
`define FTC_CFG_RANGE_BIT 7

// ----------------------------------------
// Address fields
// ----------------------------------------
`define FTC_IDX_MSB 9
`define FTC_IDX_LSB 2

// ----------------------------------------
// Reset values and the count full-scale value
// ----------------------------------------
`define FTC_CTRL_RST 8'h50
`define FTC_CFG_RST 8'h00
`define FTC_CNT_RST 8'h00
`define FTC_CNT_MAX 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define FTC_CLK_MHZ 40
`define FTC_BASE_TICK_NS 1000
`define FTC_NS_PER_US 1000

`endif

// ---- verilog/ftc_pkg.sv ----
// Types shared by the fan tachometer block
package ftc_pkg;
  typedef logic [1:0] ftc_div_t;
  typedef logic [7:0] ftc_byte_t;
endpackage

// ---- verilog/ftc_top.sv ----
// Two-channel fan tachometer counter with APB register access
//
// Functional notes
// R1: Set, the fan-two multiplier bit doubles the range chosen by speed bit and config bit 7.
// R2: Set, the fan-one multiplier bit doubles the range chosen by speed bit and config bit 7.
// R3: Bits 5:4 divide the fan-one count clock by 1, 2, 4 or 8, resetting to divide by 2.
// R4: Bits 7:6 divide the fan-two count clock by 1, 2, 4 or 8, resetting to divide by 2.
// R5: An 8-bit read-only register holds the fan-one count of scaled clocks per pulse period.
// R6: At each tachometer pulse the final count is latched and counting restarts.
// R7: Software treats the count as possibly invalid for up to two pulses after start or a change.
// R8: The count saturates at full scale instead of wrapping.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "ftc_consts.svh"

module ftc_top #(
  parameter int PRESC_W = 16,
  parameter int BASE_TICK_CYC = (`FTC_BASE_TICK_NS * `FTC_CLK_MHZ) / `FTC_NS_PER_US
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fan tachometer pulses, one per fan
  input wire logic [1:0] fan_tach
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ftc_pkg::ftc_byte_t ctrl;
  ftc_pkg::ftc_byte_t fan_one_config;
  ftc_pkg::ftc_byte_t fan_two_config;
  ftc_pkg::ftc_byte_t tach_count [2];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic setup_ph = psel & ~penable & ~pready;
  wire logic access_done = psel & penable & pready;
  wire logic [7:0] word_idx = paddr[`FTC_IDX_MSB:`FTC_IDX_LSB];
  wire logic aligned = (paddr[`FTC_IDX_LSB-1:0] == '0) & (paddr[11:`FTC_IDX_MSB+1] == '0);
  wire logic hit_ctrl = aligned & (word_idx == `FTC_IDX_CTRL);
  wire logic hit_cnt1 = aligned & (word_idx == `FTC_IDX_CNT1);
  wire logic hit_cnt2 = aligned & (word_idx == `FTC_IDX_CNT2);
  wire logic hit_cfg1 = aligned & (word_idx == `FTC_IDX_CFG1);
  wire logic hit_cfg2 = aligned & (word_idx == `FTC_IDX_CFG2);
  wire logic mapped = hit_ctrl | hit_cnt1 | hit_cnt2 | hit_cfg1 | hit_cfg2;
  wire logic wr_ctrl = access_done & pwrite & hit_ctrl;
  wire logic wr_cfg1 = access_done & pwrite & hit_cfg1;
  wire logic wr_cfg2 = access_done & pwrite & hit_cfg2;
  // Count registers ignore writes
  wire ftc_pkg::ftc_byte_t rd_byte =
    hit_ctrl ? ctrl :
    hit_cnt1 ? tach_count[0] :  // [R5]
    hit_cnt2 ? tach_count[1] :
    hit_cfg1 ? fan_one_config :
    hit_cfg2 ? fan_two_config : `FTC_CNT_RST;
  wire logic [31:0] next_prdata = {24'h000000, rd_byte};

  // No wait state: answer is prepared during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
      prdata <= 32'h00000000;
      pslverr <= 1'h0;
    end else begin
      pready <= setup_ph;
      prdata <= setup_ph ? next_prdata : 32'h00000000;
      pslverr <= setup_ph & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `FTC_CTRL_RST;  // [R3] [R4]
      fan_one_config <= `FTC_CFG_RST;
      fan_two_config <= `FTC_CFG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[7:0];
      end
      if (wr_cfg1) begin
        fan_one_config <= pwdata[7:0];
      end
      if (wr_cfg2) begin
        fan_two_config <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Per-fan scaling selects
  // ----------------------------------------
  wire logic [1:0] range_sel [2];
  wire logic mult_on [2];
  wire ftc_pkg::ftc_div_t div_code [2];
  assign range_sel[0] = {fan_one_config[`FTC_CFG_RANGE_BIT], ctrl[`FTC_SPD1_BIT]};
  assign range_sel[1] = {fan_two_config[`FTC_CFG_RANGE_BIT], ctrl[`FTC_SPD2_BIT]};
  assign mult_on[0] = ctrl[`FTC_MUL1_BIT];  // [R2]
  assign mult_on[1] = ctrl[`FTC_MUL2_BIT];  // [R1]
  assign div_code[0] = ctrl[`FTC_DIV1_LSB +: 2];  // [R3]
  assign div_code[1] = ctrl[`FTC_DIV2_LSB +: 2];  // [R4]

  // ----------------------------------------
  // Tachometer counting, one channel per fan
  // ----------------------------------------
  ftc_tach_channel #(
    .PRESC_W(PRESC_W),
    .BASE_TICK_CYC(BASE_TICK_CYC)
  ) fan_one_ch_i (
    .pclk(pclk),
    .presetn(presetn),
    .div_code(div_code[0]),  // [R3]
    .range_sel(range_sel[0]),  // [R2]
    .mult_on(mult_on[0]),  // [R2]
    .tach(fan_tach[0]),
    .count(tach_count[0])  // [R5] [R6]
  );

  // Same channel; its count sits one index above fan one
  ftc_tach_channel #(
    .PRESC_W(PRESC_W),
    .BASE_TICK_CYC(BASE_TICK_CYC)
  ) fan_two_ch_i (
    .pclk(pclk),
    .presetn(presetn),
    .div_code(div_code[1]),  // [R4]
    .range_sel(range_sel[1]),  // [R1]
    .mult_on(mult_on[1]),  // [R1]
    .tach(fan_tach[1]),
    .count(tach_count[1])  // [R6]
  );

endmodule

// ----------------------------------------
// One tachometer channel: prescaler, running count and latch
// ----------------------------------------
module ftc_tach_channel #(
  parameter int PRESC_W = 16,
  parameter int BASE_TICK_CYC = (`FTC_BASE_TICK_NS * `FTC_CLK_MHZ) / `FTC_NS_PER_US
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scaling controls
  input wire ftc_pkg::ftc_div_t div_code,
  input wire logic [1:0] range_sel,
  input wire logic mult_on,
  // Tachometer pulse from the fan
  input wire logic tach,
  // Final count of the last pulse period
  output ftc_pkg::ftc_byte_t count
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic tach_prev;
  logic [PRESC_W-1:0] presc;
  ftc_pkg::ftc_byte_t run_count;

  // ----------------------------------------
  // Scaled tick and pulse detect
  // ----------------------------------------
  // Doubling the range halves the count rate; divisor slows it by 2**code
  wire logic [2:0] shift = {1'h0, div_code} + {1'h0, range_sel}
                           + {2'h0, mult_on};  // [R1] [R2] [R3] [R4]
  wire logic [PRESC_W-1:0] presc_lim =
    PRESC_W'(BASE_TICK_CYC << shift) - PRESC_W'(1);
  // Compare, not equality: a divisor change may leave presc above the new limit
  wire logic tick = (presc >= presc_lim);
  // Falling edge only; a reset value of zero cannot fake one
  wire logic pulse = tach_prev & ~tach;
  wire logic sat = (run_count == `FTC_CNT_MAX);
  wire logic [PRESC_W-1:0] next_presc = (pulse | tick) ? '0 : presc + PRESC_W'(1);
  // Hold full scale so a fan too slow for the range reads all ones at its next pulse
  wire ftc_pkg::ftc_byte_t next_run_count =
    pulse ? `FTC_CNT_RST :
    (tick & ~sat) ? run_count + 8'h01 :  // [R8]
    run_count;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tach_prev <= 1'h0;
    end else begin
      tach_prev <= tach;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else begin
      presc <= next_presc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_count <= `FTC_CNT_RST;
    end else begin
      run_count <= next_run_count;
    end
  end

  // A count in flight when the divisor changes mixes both rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `FTC_CNT_RST;
    end else if (pulse) begin
      count <= run_count;  // [R6]
    end
  end

endmodule

// ---- verification/ftc_properties.sv ----
// Bus checks for the fan tachometer block
`timescale 1ns/1ps
module ftc_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fan pulses
  input wire logic [1:0] fan_tach
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("setup without answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_sel; pready |-> psel && penable; endproperty
  a_sel: assert property (p_sel) else $error("stray ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside access");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_map; pready && paddr[11:4] == 8'h16 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_mis; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_mis: assert property (p_mis) else $error("misaligned accepted");
  c_err: cover property (pslverr);
  c_rd: cover property (pready && !pwrite);
  c_tach: cover property ($fell(fan_tach[1]));
  c_sat: cover property (pready && paddr == 12'h164 && prdata[7:0] == 8'hFF);
endmodule
bind ftc_top ftc_properties ftc_properties_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .fan_tach);

// ---- verification/ftc_fan_model.sv ----
// Two fans giving square tach waves, period in clocks
`timescale 1ns/1ps
module ftc_fan_model (
  // Clock
  input wire logic pclk,
  // Pulse periods in clocks
  input wire logic [15:0] per0,
  input wire logic [15:0] per1,
  // Tach outputs, idle high
  output logic [1:0] fan_tach = 2'h3
);
  int c0 = 0;
  int c1 = 0;
  // Free running: a real fan does not stop for reset
  always @(posedge pclk) begin
    c0 <= c0 + 1 >= per0 ? 0 : c0 + 1;
    c1 <= c1 + 1 >= per1 ? 0 : c1 + 1;
    fan_tach <= {c1 < per1 / 2, c0 < per0 / 2};
  end
endmodule

// ---- verification/fan_tach_counter_tb.sv ----
// Self-checking bench for the fan tachometer block
`timescale 1ns/1ps
module fan_tach_counter_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] per0 = 16'h40, per1 = 16'h80;
  logic [1:0] fan_tach;
  int errors = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  ftc_top #(.BASE_TICK_CYC(1)) ftc_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fan_tach);
  ftc_fan_model ftc_fan_model_i (.pclk, .per0, .per1, .fan_tach);
  task chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // Prescaler restarts at each pulse and the count lands one below the ideal, so one count either way is fair
  task near(string n, logic [31:0] s, logic [31:0] e);
    chk(n, s + 32'h1 - e <= 32'h2 ? e : s, e);
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Runs before the first fan fall after reset
  task t_bus;
    apb(1'h0, 12'h160, 32'h0);
    chk("ctrl", rd, 32'h50);
    apb(1'h1, 12'h164, 32'hAA);
    apb(1'h0, 12'h164, 32'h0);
    chk("cnt1", {rd[30:0], er}, 32'h0);
    apb(1'h0, 12'h003, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
  endtask
  task t_div;
    int s;
    for (int c = 0; c < 5; c++) begin
      s = c < 4 ? c : 2;
      apb(1'h1, 12'h160, c < 4 ? 32'(c * 32'h50) : 32'h5C);
      repeat (400) @(posedge pclk);
      apb(1'h0, 12'h164, 32'h0);
      near("cnt1", rd, 32'(64 >> s));
      apb(1'h0, 12'h168, 32'h0);
      near("cnt2", rd, 32'(128 >> s));
    end
  endtask
  task t_sat;
    per0 <= 16'h258;
    apb(1'h1, 12'h160, 32'h0);
    repeat (1900) @(posedge pclk);
    apb(1'h0, 12'h164, 32'h0);
    chk("sat", rd, 32'hFF);
  endtask
  // Range bits: fan-one config bit 7, fan-two speed bit
  task t_rng;
    apb(1'h1, 12'h16C, 32'h80);
    apb(1'h1, 12'h160, 32'h02);
    repeat (400) @(posedge pclk);
    apb(1'h0, 12'h16C, 32'h0);
    chk("cfg1", rd, 32'h80);
    apb(1'h0, 12'h164, 32'h0);
    near("rng1", rd, 32'h10);
    apb(1'h0, 12'h168, 32'h0);
    near("rng2", rd, 32'h40);
    apb(1'h1, 12'h16C, 32'h0);
  endtask
  // Reset in mid-run brings the settings back
  task t_rst;
    apb(1'h1, 12'h170, 32'h80);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h160, 32'h0);
    chk("ctrl_rst", rd, 32'h50);
    apb(1'h0, 12'h170, 32'h0);
    chk("cfg2_rst", rd, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_bus;
    t_div;
    t_rng;
    t_sat;
    t_rst;
    test_done;
  end
  initial begin
    repeat (8000) @(posedge pclk);
    errors++;
    test_done;
  end
endmodule
